// ### verilog/cmsre_pkg.sv
// Constants, types and opcode patterns for the multiply/stack/return executor.
// Assumes a four-phase instruction cycle driven by one core clock.
//
// Contract
// - Literal multiply: W times literal into product
// - File multiply: W times file into product
// - Multiplies never touch any status flag
// - Bank bit selects access bank or bank register
// - Extended set: low access addresses become indexed
// - Negate file: two's complement, five flags updated
// - Pop discards top of return stack
// - Push stores PC plus two on stack
// - Relative call pushes, jumps by doubled offset
// - Software reset restores all master-clear values
// - Interrupt return pops PC, sets one enable
// - Fast bit restores shadow working, flags, bank
// - Subroutine return pops PC, latches kept
// - Literal return loads W and pops PC
// - Rotate left through carry, flags C N Z
// - Destination bit picks W or file
package cmsre_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam logic [4:0] STACK_TOP_SLOT = 5'h1f;

	// ----------------------------------------
	// Opcode patterns
	// ----------------------------------------
	localparam logic [15:0] OPC_NOP = 16'h0000;
	localparam logic [15:0] OPC_POP = 16'h0006;
	localparam logic [15:0] OPC_PUSH = 16'h0005;
	localparam logic [15:0] OPC_RESET = 16'h00ff;
	localparam logic [14:0] OPC_INT_RETURN = 15'h0008;
	localparam logic [14:0] OPC_SUB_RETURN = 15'h0009;
	localparam logic [7:0] OPC_MUL_LIT = 8'h0d;
	localparam logic [7:0] OPC_LIT_RETURN = 8'h0c;
	localparam logic [6:0] OPC_MUL_FILE = 7'h01;
	localparam logic [6:0] OPC_NEGATE = 7'h36;
	localparam logic [5:0] OPC_ROT_LEFT = 6'h0d;
	localparam logic [4:0] OPC_REL_CALL = 5'h1b;
	localparam logic [3:0] SECOND_WORD_NIBBLE = 4'hf;

	// ----------------------------------------
	// Field positions and addressing
	// ----------------------------------------
	localparam int FAST_BIT = 0;
	localparam int BANK_BIT = 8;
	localparam int DEST_BIT = 9;
	localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_DIGIT = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_OVER = 3;
	localparam int FLAG_NEG = 4;

	// ----------------------------------------
	// Register port map
	// ----------------------------------------
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_WORK = 4'h1;
	localparam logic [3:0] REG_FLAGS = 4'h2;
	localparam logic [3:0] REG_BANK = 4'h3;
	localparam logic [3:0] REG_PROD_LOW = 4'h4;
	localparam logic [3:0] REG_PROD_HIGH = 4'h5;
	localparam logic [3:0] REG_PC_HIGH = 4'h6;
	localparam logic [3:0] REG_PC_UPPER = 4'h7;
	localparam logic [3:0] REG_GIE = 4'h8;
	localparam logic [3:0] REG_STACK_PTR = 4'h9;
	localparam int CTRL_EXT_BIT = 0;
	localparam int GIE_HIGH_BIT = 0;
	localparam int GIE_LOW_BIT = 1;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} cmsre_phase_type;

	typedef enum logic [3:0] {
		OP_OTHER, OP_IDLE, OP_NOP, OP_MUL_LIT, OP_MUL_FILE, OP_NEGATE, OP_POP, OP_PUSH,
		OP_REL_CALL, OP_SOFT_RESET, OP_INT_RETURN, OP_SUB_RETURN, OP_LIT_RETURN, OP_ROT_LEFT
	} cmsre_op_type;

	typedef struct packed {
		logic [7:0] working;
		logic [7:0] flags;
		logic [7:0] bank_select_register;
		logic [7:0] product_high;
		logic [7:0] product_low;
		logic [7:0] pc_high_latch;
		logic [7:0] pc_upper_latch;
		logic [7:0] shadow_working;
		logic [7:0] shadow_flags;
		logic [7:0] shadow_bank_select;
		logic [PC_W-1:0] pc;
		logic high_priority_global_enable;
		logic low_priority_global_enable;
		logic ext_enable;
		logic [SP_W-1:0] stack_ptr;
	} cmsre_core_type;

	localparam cmsre_core_type CORE_RESET = '0;

endpackage

// ### verilog/cmsre_exec.sv
// Executor for multiplies, negate, stack and return opcodes of an 8-bit core.
// Program and data memories sit outside; both answer within one phase.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/10ps
module cmsre_exec (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Program memory
	output logic [20:0] prog_addr,
	input wire logic [15:0] instr,
	// Data memory
	output logic [11:0] file_addr,
	input wire logic [7:0] file_rd_data,
	output logic file_wr_en,
	output logic [7:0] file_wr_data,
	input wire logic [11:0] index_base,
	// Interrupt controller and reset sources
	input wire logic shadow_load,
	input wire logic return_low,
	output logic high_priority_global_enable,
	output logic low_priority_global_enable,
	output logic soft_reset,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata
);

	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function automatic cmsre_pkg::cmsre_op_type decode_op(input logic [15:0] i);
		if (i[15:12] == cmsre_pkg::SECOND_WORD_NIBBLE || i == cmsre_pkg::OPC_NOP)
			decode_op = cmsre_pkg::OP_NOP;
		else if (i == cmsre_pkg::OPC_POP)
			decode_op = cmsre_pkg::OP_POP;
		else if (i == cmsre_pkg::OPC_PUSH)
			decode_op = cmsre_pkg::OP_PUSH;
		else if (i == cmsre_pkg::OPC_RESET)
			decode_op = cmsre_pkg::OP_SOFT_RESET;
		else if (i[15:1] == cmsre_pkg::OPC_INT_RETURN)
			decode_op = cmsre_pkg::OP_INT_RETURN;
		else if (i[15:1] == cmsre_pkg::OPC_SUB_RETURN)
			decode_op = cmsre_pkg::OP_SUB_RETURN;
		else if (i[15:8] == cmsre_pkg::OPC_MUL_LIT)
			decode_op = cmsre_pkg::OP_MUL_LIT;
		else if (i[15:8] == cmsre_pkg::OPC_LIT_RETURN)
			decode_op = cmsre_pkg::OP_LIT_RETURN;
		else if (i[15:9] == cmsre_pkg::OPC_MUL_FILE)
			decode_op = cmsre_pkg::OP_MUL_FILE;
		else if (i[15:9] == cmsre_pkg::OPC_NEGATE)
			decode_op = cmsre_pkg::OP_NEGATE;
		else if (i[15:10] == cmsre_pkg::OPC_ROT_LEFT)
			decode_op = cmsre_pkg::OP_ROT_LEFT;
		else if (i[15:11] == cmsre_pkg::OPC_REL_CALL)
			decode_op = cmsre_pkg::OP_REL_CALL;
		else
			decode_op = cmsre_pkg::OP_OTHER;
	endfunction

	function automatic logic [11:0] file_address(input logic [7:0] f, input logic bank,
		input logic [7:0] bank_sel, input logic ext, input logic [11:0] base);
		if (bank)
			file_address = {bank_sel[3:0], f};
		else if (ext && f <= cmsre_pkg::ACCESS_LIMIT)
			file_address = 12'(base + {4'h0, f});
		else if (f <= cmsre_pkg::ACCESS_LIMIT)
			file_address = {4'h0, f};
		else
			file_address = {cmsre_pkg::ACCESS_HIGH_BANK, f};
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	cmsre_pkg::cmsre_core_type core, next_core;
	cmsre_pkg::cmsre_phase_type phase, next_phase;
	cmsre_pkg::cmsre_op_type op, next_op;
	logic [15:0] ir, next_ir;
	logic [7:0] operand, next_operand;
	logic [7:0] result, next_result;
	logic [7:0] res_flags, next_res_flags;
	logic flush, next_flush;
	logic [11:0] next_file_addr;
	logic [7:0] next_rdata;
	logic [20:0] stack [1:31];
	logic [20:0] top_of_stack;
	logic [20:0] pc_plus2;
	logic [8:0] neg_sum;
	logic [15:0] product;
	logic stack_we;
	logic [4:0] stack_slot;
	logic wr;

	assign top_of_stack = (core.stack_ptr == 5'h00) ? 21'h000000 : stack[core.stack_ptr];
	assign pc_plus2 = core.pc + 21'h000002;
	assign wr = (phase == cmsre_pkg::PH_WRITE);
	assign prog_addr = core.pc;
	assign file_wr_data = result;
	assign high_priority_global_enable = core.high_priority_global_enable;
	assign low_priority_global_enable = core.low_priority_global_enable;
	assign soft_reset = wr && op == cmsre_pkg::OP_SOFT_RESET;
	// negate always writes the file; rotate writes it only when destination bit set
	assign file_wr_en = wr && (op == cmsre_pkg::OP_NEGATE
		|| (op == cmsre_pkg::OP_ROT_LEFT && ir[cmsre_pkg::DEST_BIT]));

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		next_core = core;
		next_phase = phase;
		next_op = op;
		next_ir = ir;
		next_operand = operand;
		next_result = result;
		next_res_flags = res_flags;
		next_flush = flush;
		next_file_addr = file_addr;
		stack_we = 1'b0;
		stack_slot = core.stack_ptr;
		neg_sum = 9'({1'b0, ~operand}) + 9'h001;
		product = 16'(core.working) * 16'((op == cmsre_pkg::OP_MUL_LIT) ? ir[7:0] : operand);
		// Software and interrupt side first, so instruction effects win
		if (shadow_load)
		begin
			next_core.shadow_working = core.working;
			next_core.shadow_flags = core.flags;
			next_core.shadow_bank_select = core.bank_select_register;
		end
		if (reg_write)
		begin
			case (reg_addr)
				cmsre_pkg::REG_CTRL: next_core.ext_enable = reg_wdata[cmsre_pkg::CTRL_EXT_BIT];
				cmsre_pkg::REG_BANK: next_core.bank_select_register = {4'h0, reg_wdata[3:0]};
				cmsre_pkg::REG_PC_HIGH: next_core.pc_high_latch = reg_wdata;
				cmsre_pkg::REG_PC_UPPER: next_core.pc_upper_latch = {3'h0, reg_wdata[4:0]};
				cmsre_pkg::REG_GIE:
				begin
					next_core.high_priority_global_enable = reg_wdata[cmsre_pkg::GIE_HIGH_BIT];
					next_core.low_priority_global_enable = reg_wdata[cmsre_pkg::GIE_LOW_BIT];
				end
				default: ;
			endcase
		end
		unique case (phase)
			cmsre_pkg::PH_DECODE:
			begin
				next_phase = cmsre_pkg::PH_READ;
				next_ir = instr;
				// lone second word decodes as no-op
				next_op = flush ? cmsre_pkg::OP_IDLE : decode_op(instr);
				next_file_addr = file_address(instr[7:0], instr[cmsre_pkg::BANK_BIT],
					core.bank_select_register, core.ext_enable, index_base);
			end
			cmsre_pkg::PH_READ:
			begin
				next_phase = cmsre_pkg::PH_PROCESS;
				next_operand = file_rd_data;
			end
			cmsre_pkg::PH_PROCESS:
			begin
				next_phase = cmsre_pkg::PH_WRITE;
				next_res_flags = core.flags;
				next_result = operand;
				if (op == cmsre_pkg::OP_NEGATE)
				begin
					next_result = neg_sum[7:0];
					next_res_flags[cmsre_pkg::FLAG_CARRY] = neg_sum[8];
					next_res_flags[cmsre_pkg::FLAG_DIGIT] = (operand[3:0] == 4'h0);
					next_res_flags[cmsre_pkg::FLAG_OVER] = (operand == 8'h80);
				end
				else if (op == cmsre_pkg::OP_ROT_LEFT)
				begin
					// bit 7 to carry, carry to bit 0
					next_result = {operand[6:0], core.flags[cmsre_pkg::FLAG_CARRY]};
					next_res_flags[cmsre_pkg::FLAG_CARRY] = operand[7];
				end
				next_res_flags[cmsre_pkg::FLAG_ZERO] = (next_result == 8'h00);
				next_res_flags[cmsre_pkg::FLAG_NEG] = next_result[7];
			end
			cmsre_pkg::PH_WRITE:
			begin
				next_phase = cmsre_pkg::PH_DECODE;
				next_core.pc = pc_plus2;
				next_flush = 1'b0;
				unique case (op)
					cmsre_pkg::OP_MUL_LIT, cmsre_pkg::OP_MUL_FILE:
					begin
						next_core.product_high = product[15:8];
						next_core.product_low = product[7:0];
					end
					cmsre_pkg::OP_NEGATE:
						next_core.flags = res_flags;
					cmsre_pkg::OP_ROT_LEFT:
					begin
						next_core.flags = res_flags;
						if (!ir[cmsre_pkg::DEST_BIT])
							next_core.working = result;
					end
					cmsre_pkg::OP_POP:
					begin
						if (core.stack_ptr != 5'h00)
							next_core.stack_ptr = 5'(core.stack_ptr - 5'h01);
					end
					cmsre_pkg::OP_PUSH, cmsre_pkg::OP_REL_CALL:
					begin
						// return address is PC plus two
						if (core.stack_ptr != cmsre_pkg::STACK_TOP_SLOT)
						begin
							stack_slot = 5'(core.stack_ptr + 5'h01);
							next_core.stack_ptr = stack_slot;
							stack_we = 1'b1;
						end
						if (op == cmsre_pkg::OP_REL_CALL)
						begin
							next_core.pc = 21'(pc_plus2 + {{9{ir[10]}}, ir[10:0], 1'b0});
							next_flush = 1'b1;
						end
					end
					cmsre_pkg::OP_INT_RETURN, cmsre_pkg::OP_SUB_RETURN,
					cmsre_pkg::OP_LIT_RETURN:
					begin
						next_core.pc = top_of_stack;
						next_flush = 1'b1;
						if (core.stack_ptr != 5'h00)
							next_core.stack_ptr = 5'(core.stack_ptr - 5'h01);
						if (op == cmsre_pkg::OP_LIT_RETURN)
							next_core.working = ir[7:0];
						if (op == cmsre_pkg::OP_INT_RETURN && return_low)
							next_core.low_priority_global_enable = 1'b1;
						else if (op == cmsre_pkg::OP_INT_RETURN)
							next_core.high_priority_global_enable = 1'b1;
						if (op != cmsre_pkg::OP_LIT_RETURN && ir[cmsre_pkg::FAST_BIT])
						begin
							next_core.working = core.shadow_working;
							next_core.flags = core.shadow_flags;
							next_core.bank_select_register = core.shadow_bank_select;
						end
					end
					cmsre_pkg::OP_SOFT_RESET:
						// same values as external master clear
						next_core = cmsre_pkg::CORE_RESET;
					default:
					begin
						// Idle slot after a two-cycle op keeps the redirected PC
						if (flush)
							next_core.pc = core.pc;
					end
				endcase
			end
		endcase
		next_rdata = 8'h00;
		if (reg_read)
		begin
			case (reg_addr)
				cmsre_pkg::REG_CTRL: next_rdata = {7'h00, core.ext_enable};
				cmsre_pkg::REG_WORK: next_rdata = core.working;
				cmsre_pkg::REG_FLAGS: next_rdata = core.flags;
				cmsre_pkg::REG_BANK: next_rdata = core.bank_select_register;
				cmsre_pkg::REG_PROD_LOW: next_rdata = core.product_low;
				cmsre_pkg::REG_PROD_HIGH: next_rdata = core.product_high;
				cmsre_pkg::REG_PC_HIGH: next_rdata = core.pc_high_latch;
				cmsre_pkg::REG_PC_UPPER: next_rdata = core.pc_upper_latch;
				cmsre_pkg::REG_GIE: next_rdata = {6'h00, core.low_priority_global_enable,
					core.high_priority_global_enable};
				cmsre_pkg::REG_STACK_PTR: next_rdata = {3'h0, core.stack_ptr};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			core <= cmsre_pkg::CORE_RESET;
			phase <= cmsre_pkg::PH_DECODE;
			op <= cmsre_pkg::OP_IDLE;
			ir <= 16'h0000;
			operand <= 8'h00;
			result <= 8'h00;
			res_flags <= 8'h00;
			flush <= 1'b0;
			file_addr <= 12'h000;
			reg_rdata <= 8'h00;
		end
		else
		begin
			core <= next_core;
			phase <= next_phase;
			op <= next_op;
			ir <= next_ir;
			operand <= next_operand;
			result <= next_result;
			res_flags <= next_res_flags;
			flush <= next_flush;
			file_addr <= next_file_addr;
			reg_rdata <= next_rdata;
		end
	end

	// Stack storage has no reset; an empty pointer hides stale entries
	always_ff @(posedge clock)
	begin
		if (stack_we)
			stack[stack_slot] <= pc_plus2;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_PHASES: assert property (phase == cmsre_pkg::PH_DECODE |=> phase == cmsre_pkg::PH_READ
		##1 phase == cmsre_pkg::PH_PROCESS ##1 phase == cmsre_pkg::PH_WRITE)
		else $error("phase sequence broken");
	AST_FLUSH: assert property (wr && !flush && op inside {cmsre_pkg::OP_REL_CALL,
		cmsre_pkg::OP_SUB_RETURN} |=> ##1 op == cmsre_pkg::OP_IDLE ##3 $stable(core.pc))
		else $error("two-cycle op not followed by idle cycle");
	AST_MUL_LIT: assert property (wr && op == cmsre_pkg::OP_MUL_LIT |=>
		{core.product_high, core.product_low} == 16'($past(core.working)) * 16'($past(ir[7:0]))
		&& core.working == $past(core.working)) else $error("literal product wrong");
	AST_MUL_FILE: assert property (wr && op == cmsre_pkg::OP_MUL_FILE |=>
		{core.product_high, core.product_low} == 16'($past(core.working)) * 16'($past(operand))
		&& !$past(file_wr_en)) else $error("file product wrong");
	AST_MUL_FLAGS: assert property (wr && op inside {cmsre_pkg::OP_MUL_LIT,
		cmsre_pkg::OP_MUL_FILE} |=> $stable(core.flags)) else $error("multiply changed flags");
	AST_BANKED: assert property (phase == cmsre_pkg::PH_READ && ir[cmsre_pkg::BANK_BIT] |->
		file_addr == {$past(core.bank_select_register[3:0]), ir[7:0]}) else $error("bank address");
	AST_INDEXED: assert property (phase == cmsre_pkg::PH_READ && !ir[cmsre_pkg::BANK_BIT]
		&& $past(core.ext_enable) && ir[7:0] <= 8'h5f |->
		file_addr == 12'($past(index_base) + {4'h0, ir[7:0]})) else $error("indexed address");
	AST_NEGATE: assert property (wr && op == cmsre_pkg::OP_NEGATE |-> file_wr_en
		&& file_wr_data == 8'(8'h00 - operand) ##1 core.flags[cmsre_pkg::FLAG_CARRY]
		== ($past(operand) == 8'h00)) else $error("negate result or carry wrong");
	AST_POP: assert property (wr && op == cmsre_pkg::OP_POP && core.stack_ptr != 5'h00 |=>
		core.stack_ptr == 5'($past(core.stack_ptr) - 5'h01)) else $error("pop depth");
	AST_PUSH: assert property (wr && op == cmsre_pkg::OP_PUSH && core.stack_ptr != 5'h1f |=>
		top_of_stack == 21'($past(core.pc) + 21'h000002)) else $error("push value");
	AST_REL_CALL: assert property (wr && op == cmsre_pkg::OP_REL_CALL |=> core.pc ==
		21'($past(core.pc) + 21'h000002 + {{9{$past(ir[10])}}, $past(ir[10:0]), 1'b0}))
		else $error("relative call target");
	AST_SOFT_RESET: assert property (soft_reset |=> core == cmsre_pkg::CORE_RESET)
		else $error("software reset incomplete");
	AST_INT_RETURN: assert property (wr && op == cmsre_pkg::OP_INT_RETURN && !return_low |=>
		core.pc == $past(top_of_stack) && core.high_priority_global_enable)
		else $error("interrupt return");
	AST_FAST: assert property (wr && op == cmsre_pkg::OP_SUB_RETURN && ir[cmsre_pkg::FAST_BIT]
		|=> core.working == $past(core.shadow_working) && core.flags == $past(core.shadow_flags))
		else $error("fast return restore");
	AST_NO_FAST: assert property (wr && op == cmsre_pkg::OP_INT_RETURN
		&& !ir[cmsre_pkg::FAST_BIT] |=> $stable(core.working) && $stable(core.flags))
		else $error("slow return changed registers");
	AST_SUB_RETURN: assert property (wr && op == cmsre_pkg::OP_SUB_RETURN && !reg_write |=>
		core.pc == $past(top_of_stack) && $stable(core.pc_high_latch)
		&& $stable(core.pc_upper_latch)) else $error("subroutine return");
	AST_LIT_RETURN: assert property (wr && op == cmsre_pkg::OP_LIT_RETURN |=>
		core.working == $past(ir[7:0]) && core.pc == $past(top_of_stack))
		else $error("literal return");
	AST_ROTATE: assert property (wr && op == cmsre_pkg::OP_ROT_LEFT |->
		result == {operand[6:0], core.flags[cmsre_pkg::FLAG_CARRY]}
		##1 core.flags[cmsre_pkg::FLAG_CARRY] == $past(operand[7])) else $error("rotate");
	AST_DEST_W: assert property (wr && op == cmsre_pkg::OP_ROT_LEFT && !ir[cmsre_pkg::DEST_BIT]
		|-> !file_wr_en ##1 core.working == $past(result)) else $error("destination W");
	AST_SECOND_WORD: assert property (phase == cmsre_pkg::PH_DECODE && !flush
		&& instr[15:12] == 4'hf |=> op == decode_op($past(instr)) && op == cmsre_pkg::OP_NOP
		##3 !file_wr_en) else $error("second word not a no-op");

	COV_REL_CALL: cover property (wr && op == cmsre_pkg::OP_REL_CALL);
	COV_FAST_INT: cover property (wr && op == cmsre_pkg::OP_INT_RETURN && ir[0]);
	COV_NEGATE: cover property (wr && op == cmsre_pkg::OP_NEGATE);
	COV_MUL_FILE: cover property (wr && op == cmsre_pkg::OP_MUL_FILE);

endmodule

// ### dv/cmsre_mem_model.sv
// Program and data memory model for the multiply/stack/return executor.
// Assumes reads answer within one phase and writes land at the clock edge.
`timescale 1ns/10ps
module cmsre_mem_model (
	// Clock
	input wire logic clock,
	// Program memory
	input wire logic [20:0] prog_addr,
	output logic [15:0] instr,
	// Data memory
	input wire logic [11:0] file_addr,
	output logic [7:0] file_rd_data,
	input wire logic file_wr_en,
	input wire logic [7:0] file_wr_data
);
	logic [15:0] prog [0:63];
	logic [7:0] dmem [0:511];

	// ----------------------------------------
	// Contents
	// ----------------------------------------
	initial
	begin
		foreach (prog[i])
			prog[i] = 16'h0000;
		foreach (dmem[i])
			dmem[i] = 8'h00;
		prog[6'h00] = 16'hd82f;
		prog[6'h04] = 16'h0dc4;
		prog[6'h08] = 16'h6c11;
		prog[6'h0c] = 16'h3512;
		prog[6'h10] = 16'h0210;
		prog[6'h14] = 16'hf123;
		prog[6'h18] = 16'h0005;
		prog[6'h1c] = 16'h0006;
		prog[6'h20] = 16'hd817;
		prog[6'h24] = 16'h00ff;
		prog[6'h30] = 16'h0ce2;
		prog[6'h38] = 16'h0010;
		// Calls to a fast subroutine return and a fast interrupt return
		prog[6'h21] = 16'hd818;
		prog[6'h22] = 16'hd819;
		prog[6'h3a] = 16'h0013;
		prog[6'h3c] = 16'h0011;
		dmem[9'h110] = 8'hb5;
		dmem[9'h111] = 8'h3a;
		dmem[9'h112] = 8'he6;
	end

	// ----------------------------------------
	// Access
	// ----------------------------------------
	// Small image: upper address bits alias
	assign instr = prog[prog_addr[6:1]];
	assign file_rd_data = dmem[file_addr[8:0]];

	always @(posedge clock)
		if (file_wr_en)
			dmem[file_addr[8:0]] <= file_wr_data;
endmodule

// ### dv/tb.sv
// Self-checking bench for the multiply/stack/return executor.
// Assumes the memory model holds the program that this sequence follows.
`timescale 1ns/10ps
module tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [20:0] prog_addr;
	logic [15:0] instr;
	logic [11:0] file_addr;
	logic [7:0] file_rd_data;
	logic file_wr_en;
	logic [7:0] file_wr_data;
	logic low_en;
	logic high_en;
	logic soft_reset;
	logic shadow_load = 1'b0;
	logic return_low = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	int error_cnt = 0;
	int samples_checked = 0;

	always #12.5 clock = ~clock;

	cmsre_exec i_cmsre_exec (
		.clock(clock), .reset_n(reset_n), .prog_addr(prog_addr), .instr(instr),
		.file_addr(file_addr), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
		.file_wr_data(file_wr_data), .index_base(12'h100), .shadow_load(shadow_load),
		.return_low(return_low), .high_priority_global_enable(high_en),
		.low_priority_global_enable(low_en), .soft_reset(soft_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));

	cmsre_mem_model i_cmsre_mem_model (
		.clock(clock), .prog_addr(prog_addr), .instr(instr), .file_addr(file_addr),
		.file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
		.file_wr_data(file_wr_data));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	// Bounded wait; a miss shows as a compare failure
	task automatic wait_pc(input logic [7:0] pc);
		int n;
		n = 0;
		while (prog_addr !== {13'h0, pc} && n < 300)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		check(prog_addr[7:0], pc);
	endtask

	task automatic stop_test;
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		wait_pc(8'h60);
		wait_pc(8'h02);
		reg_wr(cmsre_pkg::REG_CTRL, 8'h01);
		reg_wr(cmsre_pkg::REG_BANK, 8'h01);
		wait_pc(8'h0a);
		reg_rd(cmsre_pkg::REG_WORK, 8'he2);
		reg_rd(cmsre_pkg::REG_PROD_LOW, 8'h08);
		reg_rd(cmsre_pkg::REG_PROD_HIGH, 8'had);
		reg_rd(cmsre_pkg::REG_STACK_PTR, 8'h00);
		// Shadows take W e2, flags 00, bank 01 before negate changes flags
		@(posedge clock);
		shadow_load <= 1'b1;
		@(posedge clock);
		shadow_load <= 1'b0;
		wait_pc(8'h12);
		check(i_cmsre_mem_model.dmem[9'h111], 8'hc6);
		reg_rd(cmsre_pkg::REG_FLAGS, 8'h10);
		wait_pc(8'h1a);
		reg_rd(cmsre_pkg::REG_WORK, 8'hcc);
		reg_rd(cmsre_pkg::REG_FLAGS, 8'h11);
		check(i_cmsre_mem_model.dmem[9'h112], 8'he6);
		wait_pc(8'h22);
		reg_rd(cmsre_pkg::REG_PROD_LOW, 8'h3c);
		reg_rd(cmsre_pkg::REG_PROD_HIGH, 8'h90);
		reg_rd(cmsre_pkg::REG_FLAGS, 8'h11);
		reg_rd(cmsre_pkg::REG_WORK, 8'hcc);
		wait_pc(8'h2a);
		reg_rd(cmsre_pkg::REG_WORK, 8'hcc);
		reg_rd(cmsre_pkg::REG_PROD_LOW, 8'h3c);
		wait_pc(8'h32);
		reg_rd(cmsre_pkg::REG_STACK_PTR, 8'h01);
		reg_rd(cmsre_pkg::REG_CTRL, 8'h01);
		reg_rd(cmsre_pkg::REG_BANK, 8'h01);
		reg_rd(4'hf, 8'h00);
		wait_pc(8'h3a);
		reg_rd(cmsre_pkg::REG_STACK_PTR, 8'h00);
		reg_wr(cmsre_pkg::REG_PC_HIGH, 8'h5a);
		reg_wr(cmsre_pkg::REG_PC_UPPER, 8'h13);
		reg_wr(cmsre_pkg::REG_BANK, 8'h00);
		wait_pc(8'h70);
		wait_pc(8'h42);
		reg_rd(cmsre_pkg::REG_GIE, 8'h02);
		check({7'h0, low_en}, 8'h01);
		wait_pc(8'h44);
		@(posedge clock);
		return_low <= 1'b0;
		reg_rd(cmsre_pkg::REG_WORK, 8'he2);
		reg_rd(cmsre_pkg::REG_FLAGS, 8'h00);
		reg_rd(cmsre_pkg::REG_BANK, 8'h01);
		wait_pc(8'h46);
		reg_rd(cmsre_pkg::REG_GIE, 8'h03);
		check({7'h0, high_en}, 8'h01);
		reg_rd(cmsre_pkg::REG_PC_HIGH, 8'h5a);
		reg_rd(cmsre_pkg::REG_PC_UPPER, 8'h13);
		repeat (40)
		begin
			@(posedge clock);
			#1;
			if (soft_reset === 1'b1)
				break;
		end
		check({7'h0, soft_reset}, 8'h01);
		reg_rd(cmsre_pkg::REG_CTRL, 8'h00);
		reg_rd(cmsre_pkg::REG_BANK, 8'h00);
		reg_rd(cmsre_pkg::REG_GIE, 8'h00);
		reg_rd(cmsre_pkg::REG_PROD_HIGH, 8'h00);
		stop_test();
	end

	// Program takes a few hundred cycles
	initial
	begin
		repeat (2000) @(posedge clock);
		error_cnt++;
		stop_test();
	end
endmodule
